// >>> hw/cwgen_top.v
// APB-attached complementary waveform generator with dead band and auto-shutdown
// Summary of operation
// - Shutdown drives B/D from one override field, A/C from another, polarity only on the inactive choice.
// - Override 11 high, 10 low, 01 high impedance, 00 inactive after dead band.
// - Without auto-restart, clearing shutdown works only when selected active-low inputs are high.
// - After shutdown clears, overrides hold until the first rising input event.
// - With auto-restart, flag clears itself once all selected active-low sources are high.
// - Load strobe transfers buffered values at next input event, then self-clears.
// - Load strobe is set only when already enabled, never with the enable write.
// - Three-bit mode selects steering, sync steering, full-bridge, half-bridge, push-pull.
// - Read-only status bit shows the current generator input level.
// - Each output has a polarity bit that inverts it when set.
// - Six-bit rising dead-band value, kept across resets.
// - Six-bit falling dead-band value, kept across resets.
// - Hardware sets the shutdown flag whenever shutdown takes effect.
// - Shutdown flag may be written while disabled to force shutdown outputs.
// - Auto-restart bit selects automatic or software restart.
// - Dead band counts module clocks from zero up to the programmed value.
// - Dead-band values load immediately when disabled, else at next rising or falling input edge after strobe.
// - Without auto-restart, software shutdown persists while the flag stays set.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "cwgen_defines.vh"
module cwgen_top #(
    parameter DBW  = 6,
    parameter NSRC = 5
) (
    // Clock and reset
    input  wire            core_clk,
    input  wire            rst,
    // APB slave
    input  wire            psel,
    input  wire            penable,
    input  wire            pwrite,
    input  wire [11:0]     paddr,
    input  wire [31:0]     pwdata,
    output reg  [31:0]     prdata,
    output reg             pready,
    output reg             pslverr,
    // Generator input and shutdown sources (asynchronous)
    input  wire            wave_in,
    input  wire [NSRC-1:0] shdn_src_n,
    // Outputs A..D as data and enable
    output reg  [3:0]      out_q,
    output reg  [3:0]      out_oe_q
);

    // Synchronisers: first stage read only by second stage
    reg            in_s1_q, in_s2_q, in_s3_q;
    reg [NSRC-1:0] src_s1_q, src_s2_q;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            in_s1_q  <= 1'b0;
            in_s2_q  <= 1'b0;
            in_s3_q  <= 1'b0;
            src_s1_q <= {NSRC{1'b1}};
            src_s2_q <= {NSRC{1'b1}};
        end else begin
            in_s1_q  <= wave_in;
            in_s2_q  <= in_s1_q;
            in_s3_q  <= in_s2_q;
            src_s1_q <= shdn_src_n;
            src_s2_q <= src_s1_q;
        end
    end

    wire in_rise = in_s2_q & ~in_s3_q;
    wire in_fall = ~in_s2_q & in_s3_q;

    // Configuration registers
    reg           en_q, ld_q, ren_q, shdn_q, hold_q;
    reg [2:0]     mode_q;
    reg [3:0]     pol_q;
    reg [1:0]     override_level_b_d_q, override_level_a_c_q;
    reg [NSRC-1:0] src_en_q;
    reg [DBW-1:0] rdb_buf_q, fdb_buf_q, rdb_act_q, fdb_act_q;

    // APB decode: zero-wait access phase
    wire acc   = psel & penable;
    wire wr    = acc & pwrite;
    wire hit_c = (paddr == `CWGEN_ADDR_CTRL_MAIN);
    wire hit_p = (paddr == `CWGEN_ADDR_POLARITY);
    wire hit_r = (paddr == `CWGEN_ADDR_RISE_DB);
    wire hit_f = (paddr == `CWGEN_ADDR_FALL_DB);
    wire hit_s = (paddr == `CWGEN_ADDR_SHDN_MAIN);
    wire hit_x = (paddr == `CWGEN_ADDR_SHDN_SRC);
    wire hit   = hit_c | hit_p | hit_r | hit_f | hit_s | hit_x;

    // Any selected active-low source asserted
    wire src_active = |(~src_s2_q & src_en_q);
    wire mode_rsvd  = (mode_q > `CWGEN_MODE_PUSHPULL);

    // Control, polarity and shutdown source registers
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            en_q     <= 1'b0;
            mode_q   <= `CWGEN_MODE_STEER;
            pol_q    <= 4'h0;
            src_en_q <= {NSRC{1'b0}};
        end else if (wr) begin
            if (hit_c) begin
                en_q   <= pwdata[`CWGEN_EN_BIT];
                mode_q <= pwdata[`CWGEN_MODE_HI:`CWGEN_MODE_LO];
            end
            if (hit_p)
                pol_q <= pwdata[`CWGEN_POL_HI:`CWGEN_POL_LO];
            if (hit_x)
                src_en_q <= pwdata[`CWGEN_SRC_HI:`CWGEN_SRC_LO];
        end
    end

    // Load strobe: set only if already enabled, cleared by hardware after transfer
    wire ld_set = wr & hit_c & pwdata[`CWGEN_LD_BIT] & en_q & pwdata[`CWGEN_EN_BIT];
    wire ld_xfer = ld_q & (in_rise | in_fall);
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            ld_q <= 1'b0;
        else if (ld_set)
            ld_q <= 1'b1;
        else if (ld_xfer | ~en_q)
            ld_q <= 1'b0;
    end

    // Dead-band values survive reset: only a write or a load transfer touches them
    always @(posedge core_clk) begin
        if (wr & hit_r)
            rdb_buf_q <= pwdata[`CWGEN_DB_HI:`CWGEN_DB_LO];
        if (wr & hit_f)
            fdb_buf_q <= pwdata[`CWGEN_DB_HI:`CWGEN_DB_LO];
        if (wr & hit_r & ~en_q)
            rdb_act_q <= pwdata[`CWGEN_DB_HI:`CWGEN_DB_LO];
        else if (ld_xfer)
            rdb_act_q <= rdb_buf_q;
        if (wr & hit_f & ~en_q)
            fdb_act_q <= pwdata[`CWGEN_DB_HI:`CWGEN_DB_LO];
        else if (ld_xfer)
            fdb_act_q <= fdb_buf_q;
    end

    // Shutdown flag: hardware set beats software clear
    wire sw_clr = wr & hit_s & ~pwdata[`CWGEN_SHDN_BIT];
    wire sw_set = wr & hit_s & pwdata[`CWGEN_SHDN_BIT];
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shdn_q <= 1'b1;
            ren_q  <= 1'b0;
            override_level_b_d_q <= `CWGEN_RST_OVERRIDE_LEVEL_B_D;
            override_level_a_c_q <= `CWGEN_RST_OVERRIDE_LEVEL_A_C;
        end else begin
            if (wr & hit_s) begin
                ren_q  <= pwdata[`CWGEN_REN_BIT];
                override_level_b_d_q <= pwdata[`CWGEN_OVERRIDE_LEVEL_B_D_HI:`CWGEN_OVERRIDE_LEVEL_B_D_LO];
                override_level_a_c_q <= pwdata[`CWGEN_OVERRIDE_LEVEL_A_C_HI:`CWGEN_OVERRIDE_LEVEL_A_C_LO];
            end
            if (src_active | sw_set)
                shdn_q <= 1'b1;
            else if (ren_q)
                shdn_q <= 1'b0;
            else if (sw_clr)
                shdn_q <= 1'b0;
        end
    end

    // Overrides persist from shutdown until the first rising input edge
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            hold_q <= 1'b1;
        else if (shdn_q)
            hold_q <= 1'b1;
        else if (in_rise)
            hold_q <= 1'b0;
    end

    // Dead-band timers on the rising and falling edges
    wire rdb_done, fdb_done;
    cwgen_dead_band #(.WIDTH(DBW)) u_rise_db (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (in_rise),
        .limit    (rdb_act_q),
        .done_q   (rdb_done)
    );
    cwgen_dead_band #(.WIDTH(DBW)) u_fall_db (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (in_fall),
        .limit    (fdb_act_q),
        .done_q   (fdb_done)
    );

    // Done flags are stale in the edge cycle itself; masking them stops a pulse ahead of the dead band
    wire rdb_ok = rdb_done & ~in_rise;
    wire fdb_ok = fdb_done & ~in_fall;

    // Direction latched at a rising edge for the full-bridge modes
    reg rev_q;
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            rev_q <= 1'b0;
        else if (in_rise)
            rev_q <= mode_q[0];
    end

    // Push-pull phase toggles on each rising edge
    reg pp_q;
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            pp_q <= 1'b0;
        else if (in_rise)
            pp_q <= ~pp_q;
    end

    // Raw waveform per mode before polarity, order D C B A
    reg [3:0] raw;
    always @* begin
        raw = 4'h0;
        case (mode_q)
            `CWGEN_MODE_STEER, `CWGEN_MODE_SSTEER: raw = {4{in_s2_q}};
            `CWGEN_MODE_FWD_FB:   raw = {in_s2_q & fdb_done, 1'b0, 1'b0, ~rev_q};
            `CWGEN_MODE_REV_FB:   raw = {1'b0, rev_q, in_s2_q & rdb_done, 1'b0};
            `CWGEN_MODE_HALF:     raw = {~in_s2_q & fdb_ok, in_s2_q & rdb_ok,
                                         ~in_s2_q & fdb_ok, in_s2_q & rdb_ok};
            `CWGEN_MODE_PUSHPULL: raw = {in_s2_q & ~pp_q, in_s2_q & pp_q, in_s2_q & ~pp_q, in_s2_q & pp_q};
            default:              raw = 4'h0;
        endcase
    end

    // Override level of one output; polarity only on the inactive choice
    function [1:0] cwgen_ovr;
        input [1:0] sel;
        input       pol;
        input       db_done;
        begin
            case (sel)
                `CWGEN_OVR_HIGH:     cwgen_ovr = 2'h3;
                `CWGEN_OVR_LOW:      cwgen_ovr = 2'h2;
                `CWGEN_OVR_HIZ:      cwgen_ovr = 2'h0;
                default:             cwgen_ovr = {db_done, pol};
            endcase
        end
    endfunction

    // Output drive: override while disabled, shut down, held or reserved mode
    wire      force_ovr = ~en_q | shdn_q | hold_q | mode_rsvd;
    wire      db_all    = rdb_done & fdb_done;
    reg [3:0] nxt_out, nxt_oe;
    reg [1:0] ov;
    integer   i;
    always @* begin
        nxt_out = 4'h0;
        nxt_oe  = 4'h0;
        ov      = 2'h0;
        for (i = 0; i < 4; i = i + 1) begin
            if (force_ovr) begin
                ov = cwgen_ovr((i % 2 == 1) ? override_level_b_d_q : override_level_a_c_q, pol_q[i], db_all);
                nxt_out[i] = ov[0];
                nxt_oe[i]  = ov[1];
            end else begin
                nxt_out[i] = raw[i] ^ pol_q[i];
                nxt_oe[i]  = 1'b1;
            end
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_q    <= 4'h0;
            out_oe_q <= 4'h0;
        end else begin
            out_q    <= nxt_out;
            out_oe_q <= nxt_oe;
        end
    end

    // APB read mux and answer
    reg [31:0] rd;
    always @* begin
        rd = 32'h0;
        if (hit_c) rd[7:0] = {en_q, ld_q, 3'h0, mode_q};
        if (hit_p) rd[7:0] = {2'h0, in_s2_q, 1'h0, pol_q};
        if (hit_r) rd[7:0] = {2'h0, rdb_buf_q};
        if (hit_f) rd[7:0] = {2'h0, fdb_buf_q};
        if (hit_s) rd[7:0] = {shdn_q, ren_q, override_level_b_d_q, override_level_a_c_q, 2'h0};
        if (hit_x) rd[NSRC-1:0] = src_en_q;
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            if (psel & ~penable & ~pwrite)
                prdata <= rd;
        end
    end

endmodule // cwgen_top

// >>> hw/cwgen_defines.vh
// Register offsets, field positions, reset values and mode codes of the waveform generator
`ifndef CWGEN_DEFINES_VH
`define CWGEN_DEFINES_VH

// Register byte addresses
`define CWGEN_ADDR_CTRL_MAIN    12'h000
`define CWGEN_ADDR_POLARITY     12'h004
`define CWGEN_ADDR_RISE_DB      12'h008
`define CWGEN_ADDR_FALL_DB      12'h00c
`define CWGEN_ADDR_SHDN_MAIN    12'h010
`define CWGEN_ADDR_SHDN_SRC     12'h014

// generator_control_main fields
`define CWGEN_EN_BIT            7
`define CWGEN_LD_BIT            6
`define CWGEN_MODE_HI           2
`define CWGEN_MODE_LO           0

// output_polarity_control fields
`define CWGEN_IN_BIT            5
`define CWGEN_POL_HI            3
`define CWGEN_POL_LO            0

// Dead-band value field
`define CWGEN_DB_HI             5
`define CWGEN_DB_LO             0

// shutdown_control_main fields
`define CWGEN_SHDN_BIT          7
`define CWGEN_REN_BIT           6
`define CWGEN_OVERRIDE_LEVEL_B_D_HI           5
`define CWGEN_OVERRIDE_LEVEL_B_D_LO           4
`define CWGEN_OVERRIDE_LEVEL_A_C_HI           3
`define CWGEN_OVERRIDE_LEVEL_A_C_LO           2

// Shutdown source enable field
`define CWGEN_SRC_HI            4
`define CWGEN_SRC_LO            0

// Reset values
`define CWGEN_RST_OVERRIDE_LEVEL_B_D          2'h1
`define CWGEN_RST_OVERRIDE_LEVEL_A_C          2'h1
`define CWGEN_RST_DB            6'h00

// Override level encodings
`define CWGEN_OVR_INACTIVE      2'h0
`define CWGEN_OVR_HIZ           2'h1
`define CWGEN_OVR_LOW           2'h2
`define CWGEN_OVR_HIGH          2'h3

// Mode encodings
`define CWGEN_MODE_STEER        3'h0
`define CWGEN_MODE_SSTEER       3'h1
`define CWGEN_MODE_FWD_FB       3'h2
`define CWGEN_MODE_REV_FB       3'h3
`define CWGEN_MODE_HALF         3'h4
`define CWGEN_MODE_PUSHPULL     3'h5

`endif

// >>> hw/cwgen_dead_band.v
// Dead-band counter: counts module clocks from zero up to a programmed value
`timescale 1ns/1ps
module cwgen_dead_band #(
    parameter WIDTH = 6
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             rst,
    // Control
    input  wire             start,
    input  wire [WIDTH-1:0] limit,
    // Status
    output reg              done_q
);

    reg [WIDTH-1:0] count_q;
    reg             busy_q;

    // Restart on every start pulse; done holds until the next start
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_q <= {WIDTH{1'b0}};
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
        end else if (start) begin
            count_q <= {WIDTH{1'b0}};
            busy_q  <= (limit != {WIDTH{1'b0}});
            done_q  <= (limit == {WIDTH{1'b0}});
        end else if (busy_q) begin
            if (count_q + 1'b1 >= limit) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end
            count_q <= count_q + 1'b1;
        end
    end

endmodule // cwgen_dead_band

// >>> sim/cwgen_top_sva.sv
// Port-level assertions for the waveform generator top
`timescale 1ns/1ps
module cwgen_top_sva #(
    parameter DBW  = 6,
    parameter NSRC = 5
) (
    // Clock and reset
    input wire            core_clk,
    input wire            rst,
    // APB
    input wire            psel,
    input wire            penable,
    input wire            pwrite,
    input wire [11:0]     paddr,
    input wire [31:0]     pwdata,
    input wire [31:0]     prdata,
    input wire            pready,
    input wire            pslverr,
    // Generator pins
    input wire            wave_in,
    input wire [NSRC-1:0] shdn_src_n,
    input wire [3:0]      out_q,
    input wire [3:0]      out_oe_q
);
    reg  [7:0] sh_q [0:4];
    reg        ld_ok_q;
    reg  [2:0] quiet_q;
    reg  [2:0] wst_q;
    wire       wr_c   = psel && penable && pwrite && pready;
    wire       rd_c   = pready && !pwrite && !pslverr;
    wire       ovr_on = quiet_q == 3'h7 && (!sh_q[0][7] || sh_q[0][2:1] == 2'h3) && sh_q[4][5] && sh_q[4][3];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Shadow of written bytes; dead band not reset, as in the device
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sh_q[0] <= 8'h00;
            sh_q[1] <= 8'h00;
            sh_q[4] <= 8'h94;
            ld_ok_q <= 1'b0;
            quiet_q <= 3'h0;
            wst_q   <= 3'h0;
        end else begin
            quiet_q <= wr_c ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
            wst_q   <= (wave_in != $past(wave_in)) ? 3'h0 : wst_q + {2'h0, wst_q != 3'h7};
            if (wr_c && paddr <= 12'h010 && paddr[1:0] == 2'h0)
                sh_q[paddr[4:2]] <= pwdata[7:0];
            if (wr_c && paddr == 12'h000)
                ld_ok_q <= sh_q[0][7] && pwdata[7] && pwdata[6];
        end
    end
    property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready not single after setup");
    property p_hi; rd_c |-> prdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits not zero");
    property p_err; pready && paddr > 12'h014 |-> pslverr && (pwrite || prdata == 32'h0); endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ovr; ovr_on
        |-> out_oe_q == 4'hf && out_q == {sh_q[4][4], sh_q[4][2], sh_q[4][4], sh_q[4][2]}; endproperty
    a_ovr: assert property (p_ovr) else $error("override level wrong");
    property p_hiz; quiet_q == 3'h7 && !sh_q[0][7] && sh_q[4][3:2] == 2'h1
        |-> !out_oe_q[0] && !out_oe_q[2]; endproperty
    a_hiz: assert property (p_hiz) else $error("A/C not high impedance");
    property p_in; rd_c && paddr == 12'h004 && wst_q == 3'h7 |-> prdata[5] == wave_in; endproperty
    a_in: assert property (p_in) else $error("input level bit wrong");
    property p_ld; rd_c && paddr == 12'h000 && !ld_ok_q |-> !prdata[6]; endproperty
    a_ld: assert property (p_ld) else $error("load strobe set illegally");
    property p_mode; rd_c && paddr == 12'h000 |-> prdata[7] == sh_q[0][7] && prdata[2:0] == sh_q[0][2:0]; endproperty
    a_mode: assert property (p_mode) else $error("enable or mode readback wrong");
    property p_pol; rd_c && paddr == 12'h004 |-> prdata[3:0] == sh_q[1][3:0]; endproperty
    a_pol: assert property (p_pol) else $error("polarity readback wrong");
    property p_db; rd_c && paddr[11:3] == 9'h001 && !sh_q[0][7]
        |-> prdata == {26'h0, paddr[2] ? sh_q[3][5:0] : sh_q[2][5:0]}; endproperty
    a_db: assert property (p_db) else $error("dead band readback wrong");
endmodule // cwgen_top_sva

// >>> sim/cwgen_switch_model.sv
// Power switch stage: gate levels seen behind the four outputs
`timescale 1ns/1ps
module cwgen_switch_model (
    // Clock
    input  wire       core_clk,
    // Drive from the generator
    input  wire [3:0] out_q,
    input  wire [3:0] out_oe_q,
    // Gate levels at the switches
    output reg  [3:0] gate
);
    initial gate = 4'h0;
    // Undriven gate toggles so a stale level never passes for a drive
    always @(posedge core_clk) begin
        gate <= (out_oe_q & out_q) | (~out_oe_q & ~gate);
    end
endmodule // cwgen_switch_model

// >>> sim/testbench.sv
// Self-checking bench for the waveform generator
`timescale 1ns/1ps
module testbench;
    // Clock, reset and bus
    reg         core_clk;
    reg         rst;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    // Generator side
    reg         wave_in;
    reg  [4:0]  shdn_src_n;
    wire [3:0]  out_q;
    wire [3:0]  out_oe_q;
    wire [3:0]  gate;
    // Bookkeeping
    reg  [64:0] exp_q[$];
    reg  [64:0] e;
    reg  [31:0] rng;
    reg  [31:0] rising_dead_band;
    reg  [31:0] dbf;
    reg  [31:0] pol;
    integer     n_errors;
    integer     cmp_count;
    integer     cyc;
    integer     i;
    cwgen_top i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wave_in(wave_in), .shdn_src_n(shdn_src_n), .out_q(out_q), .out_oe_q(out_oe_q));
    cwgen_switch_model i_sw (.core_clk(core_clk), .out_q(out_q), .out_oe_q(out_oe_q), .gate(gate));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task chk(input [63:0] name, input [31:0] exp, input [31:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("Error %0s exp %h got %h", name, exp, got);
            end
        end
    endtask
    // Idle cycle first, so release and next setup never share an edge
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            psel    <= 1'b1;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            @(posedge core_clk);
            while (pready !== 1'b1)
                @(posedge core_clk);
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input [11:0] a, input [31:0] x, input [31:0] m);
        begin
            exp_q.push_back({a > 12'h014, m, x});
            apb(1'b0, a, 32'h0);
        end
    endtask
    task wt(input integer n);
        repeat (n) @(posedge core_clk);
    endtask
    task end_sim;
        begin
            if (n_errors == 0 && cmp_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // Read completions take the oldest note
    always @(posedge core_clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            e = exp_q.pop_front();
            chk("prdata", e[31:0], prdata & e[63:32]);
            chk("pslverr", {31'h0, e[64]}, {31'h0, pslverr});
        end
    end
    // Hang guard
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            end_sim;
        end
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        wave_in = 1'b0;
        shdn_src_n = 5'h1f;
        n_errors = 0;
        cmp_count = 0;
        cyc = 0;
        rng = 32'd67;
        wt(5);
        rst <= 1'b0;
        wt(8);
        chk("oe", 32'h0, {28'h0, out_oe_q});
        rd(12'h010, 32'h94, 32'hff);
        rd(12'h018, 32'h0, 32'hffffffff);
        for (i = 0; i < 8; i = i + 1) begin
            wr(12'h000, i);
            rd(12'h000, i, 32'hff);
        end
        rng = xs(rng);
        rising_dead_band = {26'h0, rng[5:0]};
        rng = xs(rng);
        dbf = {26'h0, rng[5:0]};
        rng = xs(rng);
        pol = {28'h0, rng[3:0]};
        wr(12'h008, rising_dead_band);
        wr(12'h00c, dbf);
        wr(12'h004, pol);
        rd(12'h008, rising_dead_band, 32'hff);
        rd(12'h00c, dbf, 32'hff);
        rd(12'h004, pol, 32'h0f);
        wave_in <= 1'b1;
        wt(8);
        rd(12'h004, 32'h20, 32'h20);
        wave_in <= 1'b0;
        wr(12'h010, 32'hb8);
        wr(12'h004, 32'h0);
        wr(12'h014, 32'h01);
        wt(6);
        chk("out", 32'ha, {28'h0, out_q});
        chk("gate", 32'ha, {28'h0, gate});
        wr(12'h000, 32'h86);
        wt(6);
        chk("out", 32'ha, {28'h0, out_q});
        wr(12'h000, 32'h04);
        wr(12'h000, 32'hc4);
        rd(12'h000, 32'h84, 32'hff);
        wr(12'h000, 32'hc4);
        rd(12'h000, 32'hc4, 32'hff);
        wave_in <= 1'b1;
        wt(6);
        wave_in <= 1'b0;
        wt(10);
        rd(12'h000, 32'h84, 32'hff);
        shdn_src_n <= 5'h1e;
        wt(4);
        wr(12'h010, 32'h38);
        rd(12'h010, 32'hb8, 32'hff);
        shdn_src_n <= 5'h1f;
        wt(4);
        wr(12'h010, 32'h38);
        rd(12'h010, 32'h38, 32'hff);
        chk("out", 32'ha, {28'h0, out_q});
        wave_in <= 1'b1;
        wt(80);
        chk("out_ab", 32'h1, {30'h0, out_q[1:0]});
        wr(12'h000, 32'h04);
        wr(12'h000, 32'h86);
        wt(6);
        chk("out", 32'ha, {28'h0, out_q});
        wr(12'h000, 32'h04);
        wr(12'h000, 32'h84);
        wave_in <= 1'b0;
        shdn_src_n <= 5'h1e;
        wr(12'h010, 32'h78);
        wt(4);
        rd(12'h010, 32'hf8, 32'hff);
        chk("out", 32'ha, {28'h0, out_q});
        shdn_src_n <= 5'h1f;
        wt(6);
        rd(12'h010, 32'h78, 32'hff);
        rst <= 1'b1;
        wt(5);
        rst <= 1'b0;
        wt(4);
        rd(12'h008, rising_dead_band, 32'hff);
        rd(12'h00c, dbf, 32'hff);
        rd(12'h010, 32'h94, 32'hff);
        wt(4);
        end_sim;
    end
endmodule // testbench
bind cwgen_top cwgen_top_sva #(.DBW(DBW), .NSRC(NSRC)) i_sva (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wave_in(wave_in), .shdn_src_n(shdn_src_n), .out_q(out_q), .out_oe_q(out_oe_q));
